/* File: common/lwm_pkg.sv */
// Purpose: Shared constants and types for the indexed word load and mask execute block
// Assumes: 32-bit registers, bit 0 of an instruction or register is its most significant bit
// Notes: Field positions below are little-endian indices into the 32-bit vectors
package lwm_pkg;
  localparam int XLEN = 32;

  // Instruction encodings
  localparam logic [5:0] OP_PRIMARY = 6'h1F;
  localparam logic [9:0] XO_LOAD_UPD = 10'h037;
  localparam logic [9:0] XO_LOAD = 10'h017;
  localparam logic [9:0] XO_MASK_GEN = 10'h01D;
  localparam logic [9:0] XO_MASK_INS = 10'h21D;

  // Instruction field positions (little-endian index of least significant bit)
  localparam int F_PRIMARY_LSB = 26;
  localparam int F_TARGET_LSB = 21;
  localparam int F_BASE_LSB = 16;
  localparam int F_INDEX_LSB = 11;
  localparam int F_XO_LSB = 1;
  localparam int F_RECORD = 0;
  localparam int POS_WIDTH = 5;

  // Condition field 0 bit positions
  localparam int CR_LT = 3;
  localparam int CR_GT = 2;
  localparam int CR_EQ = 1;
  localparam int CR_SO = 0;

  // Register port map
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h0;
  localparam logic [REG_AW-1:0] REG_MASK = 4'h4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h8;
  localparam logic [REG_AW-1:0] REG_STATE = 4'hC;

  // Status and mask bit positions
  localparam int EV_DONE = 0;
  localparam int EV_ILLEGAL = 1;
  localparam int EV_ALIGN = 2;
  localparam int EV_STORAGE = 3;
  localparam int EV_W = 4;

  localparam int CTRL_LEGACY = 0;
  localparam logic CTRL_LEGACY_RESET = 1'b1;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } lwm_state_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [XLEN-1:0] data;
  } lwm_gpr_wr_t;

  typedef struct packed {
    logic en;
    logic [3:0] field;
  } lwm_cr_wr_t;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] addr;
  } lwm_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] data;
    logic alignFault;
    logic storageFault;
  } lwm_mem_rsp_t;

  typedef struct packed {
    lwm_state_t state;
    lwm_mem_req_t memReq;
    lwm_gpr_wr_t gprTgt;
    lwm_gpr_wr_t gprBase;
    lwm_cr_wr_t cr;
    logic [4:0] tgt;
    logic [4:0] base;
    logic doUpdate;
    logic [XLEN-1:0] ea;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic legacy;
    logic [XLEN-1:0] regRdata;
  } lwm_regs_t;
endpackage

/* File: hw/lwm_exec.sv */
// Purpose: Decode and execute indexed word loads and the two mask instructions
// Assumes: Register file reads are combinational and same-clock; memory answers later
// Notes: One instruction in flight; instrReady is low while a load waits
`timescale 1ns/10ps
module lwm_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [lwm_pkg::XLEN-1:0] instrWord,
  output logic instrReady,
  output logic [4:0] rdAddrSrc,
  output logic [4:0] rdAddrBase,
  output logic [4:0] rdAddrIdx,
  input wire logic [lwm_pkg::XLEN-1:0] rdDataSrc,
  input wire logic [lwm_pkg::XLEN-1:0] rdDataBase,
  input wire logic [lwm_pkg::XLEN-1:0] rdDataIdx,
  input wire logic xerSo,
  output lwm_pkg::lwm_mem_req_t memReq,
  input wire lwm_pkg::lwm_mem_rsp_t memRsp,
  output lwm_pkg::lwm_gpr_wr_t gprWrTgt,
  output lwm_pkg::lwm_gpr_wr_t gprWrBase,
  output lwm_pkg::lwm_cr_wr_t crWr,
  input wire logic [lwm_pkg::REG_AW-1:0] regAddr,
  input wire logic [lwm_pkg::XLEN-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [lwm_pkg::XLEN-1:0] regRdata,
  output logic irq
);
  logic [1:0] rstPipe_r;
  logic rstSyncN;
  lwm_pkg::lwm_regs_t r;
  lwm_pkg::lwm_regs_t n;
  logic [lwm_pkg::EV_W-1:0] evt;
  logic [lwm_pkg::EV_W-1:0] clr;
  logic [lwm_pkg::XLEN-1:0] ea;
  logic [lwm_pkg::XLEN-1:0] result;
  logic isPrimary;
  logic isLoad;
  logic isLoadUpd;
  logic isMaskGen;
  logic isMaskIns;
  logic [9:0] xo;
  logic [4:0] fTgt;
  logic [4:0] fBase;
  logic [4:0] fIdx;

  function automatic logic [4:0] regField(input logic [lwm_pkg::XLEN-1:0] w, input int lsb);
    regField = w[lsb +: 5];
  endfunction

  // Bit p counts from the most significant end; wrap case covers both gap and all-ones
  function automatic logic [lwm_pkg::XLEN-1:0] genMask(input logic [4:0] s, input logic [4:0] e);
    logic [lwm_pkg::XLEN-1:0] m;
    m = '0;
    for (int p = 0; p < lwm_pkg::XLEN; p++) begin
      if (s <= e) begin
        m[lwm_pkg::XLEN-1-p] = (5'(p) >= s) && (5'(p) <= e);
      end else begin
        m[lwm_pkg::XLEN-1-p] = (5'(p) >= s) || (5'(p) <= e);
      end
    end
    genMask = m;
  endfunction

  function automatic logic [3:0] crOf(input logic [lwm_pkg::XLEN-1:0] v, input logic so);
    logic [3:0] f;
    f = '0;
    f[lwm_pkg::CR_LT] = v[lwm_pkg::XLEN-1];
    f[lwm_pkg::CR_GT] = !v[lwm_pkg::XLEN-1] && (|v);
    f[lwm_pkg::CR_EQ] = ~(|v);
    f[lwm_pkg::CR_SO] = so;
    crOf = f;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_r[1];

  assign xo = instrWord[lwm_pkg::F_XO_LSB +: 10];
  assign fTgt = regField(instrWord, lwm_pkg::F_TARGET_LSB);
  assign fBase = regField(instrWord, lwm_pkg::F_BASE_LSB);
  assign fIdx = regField(instrWord, lwm_pkg::F_INDEX_LSB);
  assign isPrimary = instrWord[lwm_pkg::F_PRIMARY_LSB +: 6] == lwm_pkg::OP_PRIMARY;
  assign isLoadUpd = isPrimary && (xo == lwm_pkg::XO_LOAD_UPD);
  assign isLoad = isLoadUpd || (isPrimary && (xo == lwm_pkg::XO_LOAD));
  assign isMaskGen = isPrimary && (xo == lwm_pkg::XO_MASK_GEN);
  assign isMaskIns = isPrimary && (xo == lwm_pkg::XO_MASK_INS);

  assign rdAddrSrc = fTgt;
  assign rdAddrBase = fBase;
  assign rdAddrIdx = fIdx;
  assign instrReady = r.state == lwm_pkg::ST_IDLE;

  assign ea = (fBase != 5'h00) ? rdDataBase + rdDataIdx : rdDataIdx;
  // Insert reads the destination's old value through the base port
  assign result = isMaskGen ? genMask(rdDataSrc[4:0], rdDataIdx[4:0])
    : (rdDataBase & ~rdDataIdx) | (rdDataSrc & rdDataIdx);

  always_comb begin
    n = r;
    evt = '0;
    clr = '0;
    n.memReq.valid = 1'b0;
    n.gprTgt.en = 1'b0;
    n.gprBase.en = 1'b0;
    n.cr.en = 1'b0;
    unique case (r.state)
      lwm_pkg::ST_IDLE: begin
        if (instrValid) begin
          if (isLoad) begin
            n.memReq.valid = 1'b1;
            n.memReq.addr = ea;
            n.ea = ea;
            n.tgt = fTgt;
            n.base = fBase;
            n.doUpdate = isLoadUpd && (fBase != 5'h00) && (fBase != fTgt);
            n.state = lwm_pkg::ST_WAIT;
          end else if ((isMaskGen || isMaskIns) && r.legacy) begin
            n.gprTgt.en = 1'b1;
            n.gprTgt.addr = fBase;
            n.gprTgt.data = result;
            evt[lwm_pkg::EV_DONE] = 1'b1;
            if (instrWord[lwm_pkg::F_RECORD]) begin
              n.cr.en = 1'b1;
              n.cr.field = crOf(result, xerSo);
            end
          end else begin
            evt[lwm_pkg::EV_ILLEGAL] = 1'b1;
          end
        end
      end
      lwm_pkg::ST_WAIT: begin
        if (memRsp.valid) begin
          n.state = lwm_pkg::ST_IDLE;
          evt[lwm_pkg::EV_ALIGN] = memRsp.alignFault;
          evt[lwm_pkg::EV_STORAGE] = memRsp.storageFault;
          // Faulted loads write nothing and never touch CR0
          if (!memRsp.alignFault && !memRsp.storageFault) begin
            n.gprTgt.en = 1'b1;
            n.gprTgt.addr = r.tgt;
            n.gprTgt.data = memRsp.data;
            n.gprBase.en = r.doUpdate;
            n.gprBase.addr = r.base;
            n.gprBase.data = r.ea;
            evt[lwm_pkg::EV_DONE] = 1'b1;
          end
        end
      end
    endcase
    if (regWr && regAddr == lwm_pkg::REG_STATUS) begin
      clr = regWdata[lwm_pkg::EV_W-1:0];
    end
    if (regWr && regAddr == lwm_pkg::REG_MASK) begin
      n.mask = regWdata[lwm_pkg::EV_W-1:0];
    end
    if (regWr && regAddr == lwm_pkg::REG_CTRL) begin
      n.legacy = regWdata[lwm_pkg::CTRL_LEGACY];
    end
    // New event wins over a simultaneous clear
    n.status = (r.status & ~clr) | evt;
    n.regRdata = '0;
    if (regRd) begin
      unique case (regAddr)
        lwm_pkg::REG_STATUS: n.regRdata = {{(lwm_pkg::XLEN-lwm_pkg::EV_W){1'b0}}, r.status};
        lwm_pkg::REG_MASK: n.regRdata = {{(lwm_pkg::XLEN-lwm_pkg::EV_W){1'b0}}, r.mask};
        lwm_pkg::REG_CTRL: n.regRdata = {{(lwm_pkg::XLEN-1){1'b0}}, r.legacy};
        lwm_pkg::REG_STATE: n.regRdata = {{(lwm_pkg::XLEN-1){1'b0}}, r.state == lwm_pkg::ST_WAIT};
        default: n.regRdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      r <= '0;
      r.legacy <= lwm_pkg::CTRL_LEGACY_RESET;
    end else begin
      r <= n;
    end
  end

  assign memReq = r.memReq;
  assign gprWrTgt = r.gprTgt;
  assign gprWrBase = r.gprBase;
  assign crWr = r.cr;
  assign regRdata = r.regRdata;
  assign irq = |(r.status & r.mask);

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rstSyncN);

  loadAddress_a: assert property (instrReady && instrValid && isLoad |=>
    memReq.valid && memReq.addr == ($past(fBase) == 5'h00 ? $past(rdDataIdx) : $past(rdDataBase) + $past(rdDataIdx)))
    else $error("load address wrong");
  loadWait_a: assert property (instrReady && instrValid && isLoadUpd |=> !instrReady && !gprWrTgt.en)
    else $error("update load not waiting");
  baseUpdate_a: assert property (gprWrBase.en |-> $past(memRsp.valid) && !$past(memRsp.alignFault)
    && !$past(memRsp.storageFault) && gprWrBase.addr != 5'h00 && gprWrBase.addr != gprWrTgt.addr)
    else $error("illegal base update");
  loadNoCr_a: assert property (!instrReady |-> !crWr.en ##1 !crWr.en)
    else $error("load touched CR0");
  loadData_a: assert property (!instrReady && memRsp.valid && !memRsp.alignFault && !memRsp.storageFault
    |=> gprWrTgt.en && gprWrTgt.data == $past(memRsp.data))
    else $error("load data not written");
  maskAllOnes_a: assert property (instrReady && instrValid && isMaskGen && r.legacy
    && rdDataSrc[4:0] == rdDataIdx[4:0] + 5'h01 && rdDataIdx[4:0] != 5'h1F |=> gprWrTgt.data == 32'hFFFFFFFF)
    else $error("mask not all ones");
  maskInsert_a: assert property (instrReady && instrValid && isMaskIns && r.legacy |=>
    ((gprWrTgt.data ^ $past(rdDataBase)) & ~$past(rdDataIdx)) == 32'h00000000)
    else $error("mask insert changed kept bit");
  legacyOnly_a: assert property (instrReady && instrValid && (isMaskGen || isMaskIns) && !r.legacy
    |=> !gprWrTgt.en && r.status[lwm_pkg::EV_ILLEGAL])
    else $error("mask ran outside legacy");
  recordOff_a: assert property (instrReady && instrValid && !instrWord[lwm_pkg::F_RECORD] |=> !crWr.en)
    else $error("CR0 written without record");
  crSign_a: assert property (crWr.en |-> crWr.field[lwm_pkg::CR_LT] == gprWrTgt.data[31]
    && crWr.field[lwm_pkg::CR_EQ] == (gprWrTgt.data == 32'h00000000) && crWr.field[lwm_pkg::CR_SO] == $past(xerSo))
    else $error("CR0 not from result");
endmodule

/* File: tb/lwm_exec_tb.sv */
// Purpose: Self-checking bench for the indexed load and mask execute block
// Assumes: Partner model holds the register file; the bench preloads it directly
// Notes: Outputs are sampled at the falling edge to stay clear of update races
`timescale 1ns/10ps
module lwm_exec_tb;
  localparam logic [31:0] KEY = 32'hC3A5_5A3C;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [31:0] instrWord = 32'h0;
  logic xerSo = 1'b0, regWr = 1'b0, regRd = 1'b0, alignInj = 1'b0, storInj = 1'b0, instrReady, irq;
  logic [3:0] regAddr = 4'h0, lastCr;
  logic [4:0] rdAddrSrc, rdAddrBase, rdAddrIdx;
  logic [31:0] regWdata = 32'h0, rspDelay = 32'h0, rdDataSrc, rdDataBase, rdDataIdx, regRdata, lastAddr;
  int fails = 0, comparisons = 0, cycles = 0, crCnt = 0, baseCnt = 0;
  lwm_pkg::lwm_mem_req_t memReq;
  lwm_pkg::lwm_mem_rsp_t memRsp;
  lwm_pkg::lwm_gpr_wr_t gprWrTgt, gprWrBase;
  lwm_pkg::lwm_cr_wr_t crWr;
  lwm_exec lwm_exec_i (.sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .rdAddrSrc(rdAddrSrc), .rdAddrBase(rdAddrBase), .rdAddrIdx(rdAddrIdx),
    .rdDataSrc(rdDataSrc), .rdDataBase(rdDataBase), .rdDataIdx(rdDataIdx), .xerSo(xerSo), .memReq(memReq),
    .memRsp(memRsp), .gprWrTgt(gprWrTgt), .gprWrBase(gprWrBase), .crWr(crWr), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
  lwm_part_model #(.DATA_KEY(KEY)) lwm_part_model_i (.sys_clk(sys_clk), .rdAddrSrc(rdAddrSrc),
    .rdAddrBase(rdAddrBase), .rdAddrIdx(rdAddrIdx), .rdDataSrc(rdDataSrc), .rdDataBase(rdDataBase),
    .rdDataIdx(rdDataIdx), .memReq(memReq), .memRsp(memRsp), .gprWrTgt(gprWrTgt), .gprWrBase(gprWrBase),
    .rspDelay(rspDelay), .alignInj(alignInj), .storInj(storInj));
  initial forever #10 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    cycles <= cycles + 1;
    if (memReq.valid) lastAddr <= memReq.addr;
    if (crWr.en) begin
      lastCr <= crWr.field;
      crCnt <= crCnt + 1;
    end
    if (gprWrBase.en) baseCnt <= baseCnt + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  // Issue one word, then wait until the block is idle and writes have landed
  task automatic exec(input logic [31:0] w);
    int n;
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (instrReady !== 1'b1 && n < 40);
    chk("ready", 32'h1, 32'(instrReady));
    @(negedge sys_clk);
  endtask
  function automatic logic [31:0] enc(input logic [4:0] a, b, c, input logic [9:0] xo, input logic rc);
    return {lwm_pkg::OP_PRIMARY, a, b, c, xo, rc};
  endfunction
  // Bit 0 of the mask is its most significant bit
  function automatic logic [31:0] mg(input int s, input int e);
    logic [31:0] m;
    for (int i = 0; i < 32; i++) m[31-i] = (s <= e) ? (i >= s && i <= e) : !(i > e && i < s);
    return m;
  endfunction
  function automatic logic [3:0] cr0(input logic [31:0] v, input logic so);
    return {v[31], !v[31] && v != 32'h0, v == 32'h0, so};
  endfunction
  initial begin
    logic [31:0] v, m;
    int c;
    int ms[5] = '{16, 23, 5, 0, 31};
    int me[5] = '{20, 16, 4, 31, 0};
    logic [31:0] mk[2] = '{32'h000F_0F00, 32'h0A05_0F00};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_rd(4'h8, v);
    chk("ctrl reset", 32'h1, v);
    reg_rd(4'h2, v);
    chk("unmapped", 32'h0, v);
    lwm_part_model_i.general_register[0] = 32'h0000_0777;
    lwm_part_model_i.general_register[4] = 32'h0000_0100;
    lwm_part_model_i.general_register[5] = 32'h0000_2000;
    exec(enc(5'd6, 5'd0, 5'd4, lwm_pkg::XO_LOAD, 1'b1));
    chk("ea index", 32'h100, lastAddr);
    chk("load data", 32'h100 ^ KEY, lwm_part_model_i.general_register[6]);
    rspDelay <= 32'h3;
    exec(enc(5'd8, 5'd5, 5'd4, lwm_pkg::XO_LOAD_UPD, 1'b0));
    chk("ea sum", 32'h2100, lastAddr);
    chk("upd data", 32'h2100 ^ KEY, lwm_part_model_i.general_register[8]);
    chk("upd base", 32'h2100, lwm_part_model_i.general_register[5]);
    reg_rd(lwm_pkg::REG_STATUS, v);
    chk("done", 32'h1, v & 32'h1);
    fork
      exec(enc(5'd5, 5'd5, 5'd4, lwm_pkg::XO_LOAD_UPD, 1'b0));
      begin
        // State read lands while the load waits for storage
        repeat (3) @(posedge sys_clk);
        reg_rd(lwm_pkg::REG_STATE, v);
      end
    join
    chk("state busy", 32'h1, v);
    chk("same reg", 32'h2200 ^ KEY, lwm_part_model_i.general_register[5]);
    exec(enc(5'd9, 5'd0, 5'd4, lwm_pkg::XO_LOAD_UPD, 1'b0));
    chk("base zero", 32'h1, 32'(baseCnt));
    chk("load cr", 32'h0, 32'(crCnt));
    lwm_part_model_i.general_register[12] = 32'h0000_0040;
    for (int f = 0; f < 2; f++) begin
      reg_wr(lwm_pkg::REG_STATUS, 32'hF);
      alignInj <= (f == 0);
      storInj <= (f == 1);
      exec(enc(5'd10, 5'd12, 5'd4, lwm_pkg::XO_LOAD_UPD, 1'b0));
      chk("fault base", 32'h40, lwm_part_model_i.general_register[12]);
      chk("fault tgt", 32'h0, lwm_part_model_i.general_register[10]);
      reg_rd(lwm_pkg::REG_STATUS, v);
      chk("fault flag", 32'h1, 32'(v[lwm_pkg::EV_ALIGN + f]));
    end
    alignInj <= 1'b0;
    storInj <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      lwm_part_model_i.general_register[5] = 32'(ms[i]) | 32'hFFFF_FFE0;
      lwm_part_model_i.general_register[4] = 32'(me[i]) | 32'h5555_5540;
      xerSo <= (i == 3);
      c = crCnt;
      exec(enc(5'd5, 5'd6, 5'd4, lwm_pkg::XO_MASK_GEN, 1'(i != 2)));
      m = mg(ms[i], me[i]);
      chk("mask gen", m, lwm_part_model_i.general_register[6]);
      chk("gen cr cnt", 32'(c + int'(i != 2)), 32'(crCnt));
      if (i != 2) chk("gen cr", 32'(cr0(m, i == 3)), 32'(lastCr));
    end
    xerSo <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      lwm_part_model_i.general_register[6] = 32'hAAAA_AAAA;
      lwm_part_model_i.general_register[4] = mk[i];
      lwm_part_model_i.general_register[5] = 32'h5555_5555;
      exec(enc(5'd5, 5'd6, 5'd4, lwm_pkg::XO_MASK_INS, 1'(i)));
      m = (32'h5555_5555 & mk[i]) | (32'hAAAA_AAAA & ~mk[i]);
      chk("mask ins", m, lwm_part_model_i.general_register[6]);
    end
    chk("ins cr", 32'(cr0(m, 1'b0)), 32'(lastCr));
    // A zero result is the only way to reach the equal flag
    lwm_part_model_i.general_register[6] = 32'hAAAA_AAAA;
    lwm_part_model_i.general_register[4] = 32'hAAAA_AAAA;
    lwm_part_model_i.general_register[5] = 32'h0000_0000;
    exec(enc(5'd5, 5'd6, 5'd4, lwm_pkg::XO_MASK_INS, 1'b1));
    chk("ins zero", 32'h0, lwm_part_model_i.general_register[6]);
    chk("ins cr eq", 32'(cr0(32'h0, 1'b0)), 32'(lastCr));
    reg_wr(lwm_pkg::REG_CTRL, 32'h0);
    reg_wr(lwm_pkg::REG_STATUS, 32'hF);
    lwm_part_model_i.general_register[6] = 32'h1234_5678;
    exec(enc(5'd5, 5'd6, 5'd4, lwm_pkg::XO_MASK_GEN, 1'b0));
    exec(enc(5'd5, 5'd6, 5'd4, lwm_pkg::XO_MASK_INS, 1'b0));
    chk("no legacy", 32'h1234_5678, lwm_part_model_i.general_register[6]);
    reg_rd(lwm_pkg::REG_STATUS, v);
    chk("illegal", 32'h2, v & 32'h2);
    chk("irq masked", 32'h0, 32'(irq));
    reg_wr(lwm_pkg::REG_MASK, 32'h2);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq on", 32'h1, 32'(irq));
    reg_wr(lwm_pkg::REG_STATUS, 32'h2);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq clear", 32'h0, 32'(irq));
    reg_rd(lwm_pkg::REG_MASK, v);
    chk("mask rb", 32'h2, v);
    @(negedge sys_clk);
    chk("rdata idle", 32'h0, regRdata);
    report_and_stop();
  end
endmodule

/* File: tb/lwm_part_model.sv */
// Purpose: Register file and data storage facing the load and mask block
// Assumes: Register reads are combinational; one answer per storage request
// Notes: Idle data lines show the inverse of the last word, never a held value
`timescale 1ns/10ps
module lwm_part_model #(
  parameter logic [31:0] DATA_KEY = 32'hC3A5_5A3C
) (
  input wire logic sys_clk,
  input wire logic [4:0] rdAddrSrc,
  input wire logic [4:0] rdAddrBase,
  input wire logic [4:0] rdAddrIdx,
  output logic [31:0] rdDataSrc,
  output logic [31:0] rdDataBase,
  output logic [31:0] rdDataIdx,
  input wire lwm_pkg::lwm_mem_req_t memReq,
  output lwm_pkg::lwm_mem_rsp_t memRsp,
  input wire lwm_pkg::lwm_gpr_wr_t gprWrTgt,
  input wire lwm_pkg::lwm_gpr_wr_t gprWrBase,
  input wire logic [31:0] rspDelay,
  input wire logic alignInj,
  input wire logic storInj
);
  logic [31:0] general_register [32];
  logic [31:0] reqAddr = 32'h0;
  logic [31:0] lastData = 32'h0;
  lwm_pkg::lwm_mem_rsp_t rspQ = '0;
  int waitN = -1;
  assign rdDataSrc = general_register[rdAddrSrc];
  assign rdDataBase = general_register[rdAddrBase];
  assign rdDataIdx = general_register[rdAddrIdx];
  assign memRsp = rspQ;
  initial foreach (general_register[i]) general_register[i] = 32'h0;
  always @(posedge sys_clk) begin
    if (gprWrTgt.en) general_register[gprWrTgt.addr] <= gprWrTgt.data;
    if (gprWrBase.en) general_register[gprWrBase.addr] <= gprWrBase.data;
    rspQ <= '{1'b0, ~lastData, 1'b0, 1'b0};
    if (memReq.valid) begin
      reqAddr <= memReq.addr;
      waitN <= int'(rspDelay);
    end else if (waitN > 0) begin
      waitN <= waitN - 1;
    end else if (waitN == 0) begin
      // Faults are only meaningful in the answering cycle
      rspQ <= '{1'b1, reqAddr ^ DATA_KEY, alignInj, storInj};
      lastData <= reqAddr ^ DATA_KEY;
      waitN <= -1;
    end
  end
endmodule
